// File: verilog/adcr_regs.sv
// serial-port configuration register bank with digital page decode
`timescale 1ns/10ps
module adcr_regs (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // serial port pins
    input wire logic serial_select_n_in,
    input wire logic sclk_in,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_out,
    // sysref monitor observation
    input wire logic sysref_in,
    input wire logic [4:0] window_obs_in,
    // page access grants
    output logic analog_bank_enable_out,
    output logic calibration_bank_enable_out,
    output logic downconv_cd_bank_enable_out,
    output logic downconv_ab_bank_enable_out,
    output logic serial_link_bank_enable_out,
    output logic digital_bank_enable_out,
    // datapath controls
    output logic wide_output_out,
    output logic [4:0] wide_pad_bits_out,
    output logic dual_band_out,
    output logic real_decim_select_out,
    output logic osc_zero_out,
    output logic filter_bypass_out,
    output logic [7:0] decim_factor_out,
    output logic averaging_active_out,
    output logic twos_complement_out,
    output logic global_sleep_out,
    output logic fast_powerdown_out,
    output logic [1:0] capture_channel_out,
    // oscillator selection
    output logic [15:0] osc_index_out,
    output logic osc_from_regs_out,
    output logic fast_serial_select_out,
    output logic [2:0] pin_function_out
);
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] mode;
        logic [7:0] decim;
        logic [7:0] avg;
        logic [7:0] fmt;
        logic [7:0] fpd;
        logic [7:0] osc_ab;
        logic [7:0] osc_cd;
        logic [7:0] mon;
        logic [7:0] pinfn;
        logic [7:0] src;
        logic [7:0] dcab;
        logic [7:0] dccd;
        logic rst_bit;
        logic [23:0] shift;
        logic [4:0] cnt;
        logic sclk_d;
        logic sysref_d;
        logic [4:0] obs;
        logic rd_active;
        logic [7:0] rd_data;
        logic sdo;
        logic sdo_oe;
        logic [7:0] factor;
        logic [58:0] outs;
    } adcr_state_t;
    adcr_state_t st_r, st_nxt;
    logic ss_n_s, sclk_s, sdio_s, sysref_s;
    logic [4:0] obs_s;
    adcr_sync u_sync_ss (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .d_in(serial_select_n_in), .q_out(ss_n_s));
    adcr_sync u_sync_sclk (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .d_in(sclk_in), .q_out(sclk_s));
    adcr_sync u_sync_sdio (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .d_in(sdio_in), .q_out(sdio_s));
    adcr_sync u_sync_sref (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .d_in(sysref_in), .q_out(sysref_s));
    // window flags are captured only at the sysref edge, so skew settles first
    for (genvar g = 0; g < 5; g++) begin : g_obs
        adcr_sync u_sync_obs (.clk_in(clk_in), .rst_n_in(rst_n_in),
            .d_in(window_obs_in[g]), .q_out(obs_s[g]));
    end
    localparam logic [7:0] RST_VAL = adcr_pkg::RST_ZERO;
    function automatic logic [7:0] rd_mux(input adcr_state_t s, input logic [11:0] a);
        logic [7:0] v;
        v = RST_VAL;
        unique case (a)
            adcr_pkg::REG_RESET: v = {7'h00, s.rst_bit};
            adcr_pkg::REG_PAGE_ENABLE: v = s.page;
            adcr_pkg::REG_DOWNCONV_MODE: v = s.mode;
            adcr_pkg::REG_DECIMATION_RATIO: v = s.decim;
            adcr_pkg::REG_AVERAGING_CTRL: v = s.avg;
            adcr_pkg::REG_FORMAT_POWERDOWN: v = s.fmt;
            adcr_pkg::REG_FAST_PD_CAPTURE_SEL: v = s.fpd;
            adcr_pkg::REG_OSC_SELECT_AB: v = s.osc_ab;
            adcr_pkg::REG_OSC_SELECT_CD: v = s.osc_cd;
            adcr_pkg::REG_SYSREF_WINDOW_MONITOR: v = s.mon;
            adcr_pkg::REG_PIN_FUNCTION_MODE: v = s.pinfn;
            adcr_pkg::REG_OSC_SELECT_SOURCE: v = s.src;
            default: v = RST_VAL;
        endcase
        return v;
    endfunction : rd_mux
    logic sclk_rise, sclk_fall, write_now;
    logic [23:0] frame;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [2:0] dcode;
    logic byp, dconv;
    always_comb begin
        st_nxt = st_r;
        sclk_rise = sclk_s & ~st_r.sclk_d;
        sclk_fall = ~sclk_s & st_r.sclk_d;
        frame = {st_r.shift[22:0], sdio_s};
        addr = frame[adcr_pkg::ADDR_MSB:8];
        wdata = frame[7:0];
        write_now = 1'b0;
        st_nxt.sclk_d = sclk_s;
        st_nxt.sysref_d = sysref_s;
        if (ss_n_s) begin
            st_nxt.cnt = 5'h00;
            st_nxt.rd_active = 1'b0;
            st_nxt.sdo_oe = 1'b0;
        end else if (sclk_rise) begin
            st_nxt.shift = frame;
            if (st_r.cnt == adcr_pkg::FRAME_LAST) begin
                st_nxt.cnt = 5'h00;
                st_nxt.rd_active = 1'b0;
                write_now = ~frame[adcr_pkg::RW_BIT];
            end else begin
                st_nxt.cnt = st_r.cnt + 5'h01;
            end
            // after 16th bit the address is known; load read data
            if (st_r.cnt == 5'h0f && st_r.shift[14]) begin
                st_nxt.rd_active = 1'b1;
                st_nxt.rd_data = rd_mux(st_r, frame[11:0]);
            end
        end else if (sclk_fall && st_r.rd_active) begin
            // data shifts out on falling edges so the host can latch on the next
            st_nxt.sdo = st_r.rd_data[7];
            st_nxt.rd_data = {st_r.rd_data[6:0], 1'b0};
            st_nxt.sdo_oe = 1'b1;
        end else if (sclk_fall) begin
            st_nxt.sdo_oe = 1'b0;
        end
        if (write_now) begin
            unique case (addr)
                adcr_pkg::REG_RESET: st_nxt.rst_bit = wdata[0];
                adcr_pkg::REG_PAGE_ENABLE: st_nxt.page = wdata;
                default: begin
                end
            endcase
            if (st_r.page[adcr_pkg::PG_DIGITAL]) begin
                unique case (addr)
                    adcr_pkg::REG_DOWNCONV_MODE: st_nxt.mode = wdata;
                    adcr_pkg::REG_DECIMATION_RATIO: st_nxt.decim = wdata;
                    adcr_pkg::REG_AVERAGING_CTRL: st_nxt.avg = wdata;
                    adcr_pkg::REG_FORMAT_POWERDOWN: st_nxt.fmt = wdata;
                    adcr_pkg::REG_FAST_PD_CAPTURE_SEL: st_nxt.fpd = wdata;
                    adcr_pkg::REG_OSC_SELECT_AB: st_nxt.osc_ab = wdata;
                    adcr_pkg::REG_OSC_SELECT_CD: st_nxt.osc_cd = wdata;
                    adcr_pkg::REG_PIN_FUNCTION_MODE: st_nxt.pinfn = wdata;
                    adcr_pkg::REG_OSC_SELECT_SOURCE: st_nxt.src = wdata;
                    default: begin
                    end
                endcase
            end
            // shared mirror of a down-converter page location
            if (st_r.page[adcr_pkg::PG_DCONV_AB]) begin
                st_nxt.dcab = wdata;
            end
            if (st_r.page[adcr_pkg::PG_DCONV_CD]) begin
                st_nxt.dccd = wdata;
            end
        end
        // monitor flags: not sticky, replaced at each sysref rise
        if (sysref_s && !st_r.sysref_d) begin
            st_nxt.obs = obs_s;
        end
        st_nxt.mon = adcr_pkg::MON_FIXED | {1'b0, st_nxt.obs, |st_nxt.obs, 1'b0};
        dcode = st_nxt.decim[adcr_pkg::DECIM_LSB +: 3];
        unique case (dcode)
            3'h2: st_nxt.factor = 8'h04;
            3'h3: st_nxt.factor = 8'h08;
            3'h4: st_nxt.factor = 8'h10;
            3'h5: st_nxt.factor = 8'h20;
            3'h6: st_nxt.factor = 8'h40;
            3'h7: st_nxt.factor = 8'h80;
            default: st_nxt.factor = 8'h00;
        endcase
        byp = st_nxt.mode[adcr_pkg::BYPASS_BIT];
        dconv = ~byp;
        st_nxt.outs = {
            st_nxt.page[adcr_pkg::PG_ANALOG], st_nxt.page[adcr_pkg::PG_CALIB],
            st_nxt.page[adcr_pkg::PG_DCONV_CD], st_nxt.page[adcr_pkg::PG_DCONV_AB],
            st_nxt.page[adcr_pkg::PG_LINK], st_nxt.page[adcr_pkg::PG_DIGITAL],
            st_nxt.mode[adcr_pkg::WIDE_OUT_BIT],
            dconv && st_nxt.mode[adcr_pkg::REAL_BIT] == 1'b0
                && st_nxt.mode[adcr_pkg::BAND_LSB +: 2] == 2'h1,
            st_nxt.mode[adcr_pkg::REAL_BIT] & dconv,
            st_nxt.mode[adcr_pkg::REAL_BIT],
            byp,
            st_nxt.factor,
            st_nxt.avg[adcr_pkg::AVG_ON_BIT]
                && st_nxt.avg[adcr_pkg::AVG_CNT_LSB +: 2] == adcr_pkg::AVG_TWO,
            dconv | st_nxt.fmt[adcr_pkg::FORMAT_BIT],
            st_nxt.fmt[adcr_pkg::SLEEP_BIT],
            st_nxt.fpd[adcr_pkg::FAST_PD_BIT],
            st_nxt.fpd[adcr_pkg::CAPTURE_LSB +: 2],
            st_nxt.osc_cd, st_nxt.osc_ab,
            st_nxt.src == adcr_pkg::SRC_ALL_REG,
            st_nxt.src != adcr_pkg::SRC_ALL_REG
                && st_nxt.pinfn[adcr_pkg::METHOD_LSB +: 2] == adcr_pkg::METHOD_FAST,
            st_nxt.pinfn[adcr_pkg::PINFN_LSB +: 3],
            13'h0000};
        // the reset bit holds the bank at defaults while it stays set
        if (st_nxt.rst_bit) begin
            st_nxt.page = RST_VAL;
            st_nxt.mode = RST_VAL;
            st_nxt.decim = RST_VAL;
            st_nxt.avg = RST_VAL;
            st_nxt.fmt = RST_VAL;
            st_nxt.fpd = RST_VAL;
            st_nxt.osc_ab = RST_VAL;
            st_nxt.osc_cd = RST_VAL;
            st_nxt.pinfn = RST_VAL;
            st_nxt.src = RST_VAL;
            st_nxt.dcab = RST_VAL;
            st_nxt.dccd = RST_VAL;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
            st_r.mon <= adcr_pkg::MON_FIXED;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign analog_bank_enable_out = st_r.outs[58];
    assign calibration_bank_enable_out = st_r.outs[57];
    assign downconv_cd_bank_enable_out = st_r.outs[56];
    assign downconv_ab_bank_enable_out = st_r.outs[55];
    assign serial_link_bank_enable_out = st_r.outs[54];
    assign digital_bank_enable_out = st_r.outs[53];
    assign wide_output_out = st_r.outs[52];
    // low padding count is constant; fed from the package so it is not retyped
    assign wide_pad_bits_out = adcr_pkg::WIDE_PAD;
    assign dual_band_out = st_r.outs[51];
    assign osc_zero_out = st_r.outs[50];
    assign real_decim_select_out = st_r.outs[49];
    assign filter_bypass_out = st_r.outs[48];
    assign decim_factor_out = st_r.outs[47:40];
    assign averaging_active_out = st_r.outs[39];
    assign twos_complement_out = st_r.outs[38];
    assign global_sleep_out = st_r.outs[37];
    assign fast_powerdown_out = st_r.outs[36];
    assign capture_channel_out = st_r.outs[35:34];
    assign osc_index_out = st_r.outs[33:18];
    assign osc_from_regs_out = st_r.outs[17];
    assign fast_serial_select_out = st_r.outs[16];
    assign pin_function_out = st_r.outs[15:13];
    assign sdio_out = st_r.sdo;
    assign sdio_oe_out = st_r.sdo_oe;
endmodule : adcr_regs

// File: verilog/adcr_pkg.sv
// constants for the serial configuration register bank
package adcr_pkg;
    // frame layout
    localparam int FRAME_BITS = 24;
    localparam int RW_BIT = 23;
    localparam int ADDR_MSB = 19;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    // register offsets
    localparam logic [11:0] REG_RESET = 12'h000;
    localparam logic [11:0] REG_PAGE_ENABLE = 12'h005;
    localparam logic [11:0] REG_DOWNCONV_MODE = 12'h02c;
    localparam logic [11:0] REG_DECIMATION_RATIO = 12'h02d;
    localparam logic [11:0] REG_AVERAGING_CTRL = 12'h02e;
    localparam logic [11:0] REG_FORMAT_POWERDOWN = 12'h033;
    localparam logic [11:0] REG_FAST_PD_CAPTURE_SEL = 12'h034;
    localparam logic [11:0] REG_OSC_SELECT_AB = 12'h03b;
    localparam logic [11:0] REG_OSC_SELECT_CD = 12'h041;
    localparam logic [11:0] REG_SYSREF_WINDOW_MONITOR = 12'h22f;
    localparam logic [11:0] REG_PIN_FUNCTION_MODE = 12'h234;
    localparam logic [11:0] REG_OSC_SELECT_SOURCE = 12'h235;
    // page enable bits
    localparam int PG_ANALOG = 6;
    localparam int PG_CALIB = 5;
    localparam int PG_DCONV_CD = 4;
    localparam int PG_DCONV_AB = 3;
    localparam int PG_LINK = 2;
    localparam int PG_DIGITAL = 1;
    // field positions
    localparam int WIDE_OUT_BIT = 7;
    localparam int BAND_LSB = 5;
    localparam int REAL_BIT = 1;
    localparam int BYPASS_BIT = 0;
    localparam int DECIM_LSB = 4;
    localparam int AVG_ON_BIT = 3;
    localparam int AVG_CNT_LSB = 1;
    localparam int FORMAT_BIT = 3;
    localparam int SLEEP_BIT = 1;
    localparam int FAST_PD_BIT = 6;
    localparam int CAPTURE_LSB = 4;
    localparam int METHOD_LSB = 5;
    localparam int PINFN_LSB = 0;
    // reset values, fixed bits and field codes
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] MON_FIXED = 8'h81;
    localparam logic [7:0] SRC_ALL_REG = 8'hff;
    localparam logic [1:0] AVG_TWO = 2'h1;
    localparam logic [2:0] PINFN_OSC = 3'h3;
    localparam logic [1:0] METHOD_FAST = 2'h2;
    localparam logic [4:0] WIDE_PAD = 5'h0c;
endpackage : adcr_pkg

// File: verilog/adcr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module adcr_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // async level in, synced level out
    input wire logic d_in,
    output logic q_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } adcr_sync_t;
    adcr_sync_t st_r, st_nxt;
    always_comb begin
        st_nxt.s1 = d_in;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q_out = st_r.s2;
endmodule : adcr_sync

// File: sim/adcr_regs_properties.sv
// port assertions for the serial register bank
`timescale 1ns/10ps
module adcr_regs_properties (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // watched ports
    input wire logic serial_select_n_in,
    input wire logic sdio_oe_out,
    input wire logic [4:0] wide_pad_bits_out,
    input wire logic dual_band_out,
    input wire logic real_decim_select_out,
    input wire logic osc_zero_out,
    input wire logic filter_bypass_out,
    input wire logic [7:0] decim_factor_out,
    input wire logic twos_complement_out,
    input wire logic global_sleep_out,
    input wire logic [15:0] osc_index_out,
    input wire logic osc_from_regs_out,
    input wire logic fast_serial_select_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] idle_r;
    // counts quiet cycles, settings may only move inside a frame
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !serial_select_n_in) begin
            idle_r <= 4'h0;
        end else if (idle_r != 4'hf) begin
            idle_r <= idle_r + 4'h1;
        end
    end
    chk_pad_twelve: assert property (wide_pad_bits_out == 5'h0c)
        else $error("pad width not twelve");
    chk_dual_complex: assert property (dual_band_out |-> !real_decim_select_out
        && !filter_bypass_out) else $error("dual band outside complex mode");
    chk_osc_zero: assert property (osc_zero_out ==
        (real_decim_select_out && !filter_bypass_out)) else $error("zero oscillator wrong");
    // reset value of the format output settles one cycle late
    chk_twos_forced: assert property (!filter_bypass_out && $past(rst_n_in, 2)
        |-> twos_complement_out) else $error("offset binary while down-converting");
    chk_decim_legal: assert property (decim_factor_out inside {8'h00, 8'h04, 8'h08,
        8'h10, 8'h20, 8'h40, 8'h80}) else $error("illegal decimation factor");
    chk_source_excl: assert property (osc_from_regs_out |-> !fast_serial_select_out)
        else $error("fast serial select with register source");
    chk_oe_release: assert property (serial_select_n_in [*6] |-> !sdio_oe_out)
        else $error("data line driven outside frame");
    chk_idle_stable: assert property (idle_r == 4'hf |-> $stable({global_sleep_out,
        decim_factor_out, osc_index_out, filter_bypass_out})) else $error("setting moved");
    chk_reset_vals: assert property ($rose(rst_n_in) |-> !global_sleep_out
        && !sdio_oe_out && osc_index_out == 16'h0000) else $error("reset value wrong");
    cover property (dual_band_out);
    cover property (osc_from_regs_out);
    cover property ($rose(sdio_oe_out));
endmodule : adcr_regs_properties

bind adcr_regs adcr_regs_properties u_adcr_regs_properties (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .serial_select_n_in(serial_select_n_in),
    .sdio_oe_out(sdio_oe_out), .wide_pad_bits_out(wide_pad_bits_out),
    .dual_band_out(dual_band_out), .real_decim_select_out(real_decim_select_out),
    .osc_zero_out(osc_zero_out), .filter_bypass_out(filter_bypass_out),
    .decim_factor_out(decim_factor_out), .twos_complement_out(twos_complement_out),
    .global_sleep_out(global_sleep_out), .osc_index_out(osc_index_out),
    .osc_from_regs_out(osc_from_regs_out), .fast_serial_select_out(fast_serial_select_out));

// File: sim/adcr_host_model.sv
// serial host model that shifts frames into the bank
`timescale 1ns/10ps
module adcr_host_model (
    // clock
    input wire logic clk_in,
    // device side of the data line
    input wire logic sdio_out_in,
    input wire logic sdio_oe_in,
    // pins toward the device
    output logic serial_select_n_out,
    output logic sclk_out,
    output logic sdio_line_out
);
    logic drv_r;
    logic bit_r;
    logic [47:0] shift_r;
    // released line falls to its pull-down level
    assign sdio_line_out = sdio_oe_in ? sdio_out_in : (drv_r & bit_r);
    initial begin
        serial_select_n_out = 1'b1;
        sclk_out = 1'b0;
        drv_r = 1'b0;
        bit_r = 1'b0;
        shift_r = 48'h0;
    end
    // n bits msb first in one select-low burst; sclk idles low
    task automatic burst(input logic [47:0] bits, input int n, input logic rd);
        @(negedge clk_in);
        serial_select_n_out = 1'b0;
        repeat (8) @(negedge clk_in);
        for (int i = n - 1; i >= 0; i--) begin
            sclk_out = 1'b0;
            drv_r = !(rd && (i % 24) < 8);
            bit_r = bits[i];
            repeat (8) @(negedge clk_in);
            sclk_out = 1'b1;
            shift_r = {shift_r[46:0], sdio_line_out};
            repeat (8) @(negedge clk_in);
        end
        serial_select_n_out = 1'b1;
        drv_r = 1'b0;
        repeat (8) @(negedge clk_in);
        sclk_out = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask : burst
endmodule : adcr_host_model

// File: sim/adcr_regs_bench.sv
// self-checking bench for the serial register bank
`timescale 1ns/10ps
module adcr_regs_bench;
    logic clk_in, rst_n_in, sysref_in, sdio_out, sdio_oe_out;
    logic [4:0] obs, pad;
    wire logic sel_n, sclk, sdio;
    logic [5:0] pg;
    logic wide, dual, realsel, oszero, byp, avg, twos, sleep, fpd, fromreg, fast;
    logic [7:0] dec;
    logic [1:0] cap;
    logic [2:0] pfn;
    logic [15:0] osc;
    int fails, samples_checked;
    adcr_regs u_adcr_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .serial_select_n_in(sel_n),
        .sclk_in(sclk), .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out),
        .sysref_in(sysref_in), .window_obs_in(obs), .analog_bank_enable_out(pg[5]),
        .calibration_bank_enable_out(pg[4]), .downconv_cd_bank_enable_out(pg[3]),
        .downconv_ab_bank_enable_out(pg[2]), .serial_link_bank_enable_out(pg[1]),
        .digital_bank_enable_out(pg[0]), .wide_output_out(wide), .wide_pad_bits_out(pad),
        .dual_band_out(dual), .real_decim_select_out(realsel), .osc_zero_out(oszero),
        .filter_bypass_out(byp), .decim_factor_out(dec), .averaging_active_out(avg),
        .twos_complement_out(twos), .global_sleep_out(sleep), .fast_powerdown_out(fpd),
        .capture_channel_out(cap), .osc_index_out(osc), .osc_from_regs_out(fromreg),
        .fast_serial_select_out(fast), .pin_function_out(pfn));
    adcr_host_model u_adcr_host_model (.clk_in(clk_in), .sdio_out_in(sdio_out),
        .sdio_oe_in(sdio_oe_out), .serial_select_n_out(sel_n), .sclk_out(sclk),
        .sdio_line_out(sdio));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        u_adcr_host_model.burst({28'h0, a, d}, 24, 1'b0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        u_adcr_host_model.burst({28'h8, a, 8'h00}, 24, 1'b1);
        chk("readback", {8'h00, e}, {8'h00, u_adcr_host_model.shift_r[7:0]});
    endtask : rd
    task automatic t_reset;
        logic [11:0] a[10] = '{12'h005, 12'h02c, 12'h02d, 12'h02e, 12'h033, 12'h034,
            12'h03b, 12'h041, 12'h234, 12'h235};
        chk("banks", 16'h0000, {10'h0, pg});
        wr(12'h005, 8'h02);
        for (int i = 1; i < 10; i++) rd(a[i], 8'h00);
        rd(12'h22f, 8'h81);
    endtask : t_reset
    task automatic t_pages;
        wr(12'h005, 8'h7e);
        chk("banks", 16'h003f, {10'h0, pg});
        rd(12'h005, 8'h7e);
        wr(12'h005, 8'h28);
        chk("banks", 16'h0014, {10'h0, pg});
        wr(12'h033, 8'h12);
        chk("sleep", 16'h0000, {15'h0, sleep});
        wr(12'h005, 8'h02);
        wr(12'h033, 8'h12);
        chk("sleep", 16'h0001, {15'h0, sleep});
        rd(12'h033, 8'h12);
        wr(12'h033, 8'h10);
        chk("sleep", 16'h0000, {15'h0, sleep});
    endtask : t_pages
    task automatic t_mode;
        logic [7:0] v[5] = '{8'h81, 8'h22, 8'h20, 8'h40, 8'h00};
        logic [5:0] e[5] = '{6'h22, 6'h0d, 6'h11, 6'h01, 6'h01};
        for (int i = 0; i < 5; i++) begin
            wr(12'h02c, v[i]);
            chk("mode", {10'h0, e[i]}, {10'h0, wide, dual, realsel, oszero, byp, twos});
        end
        chk("pad", 16'h000c, {11'h0, pad});
        wr(12'h02c, 8'h01);
        wr(12'h033, 8'h18);
        chk("format", 16'h0001, {15'h0, twos});
    endtask : t_mode
    task automatic t_decim;
        for (int c = 0; c < 8; c++) begin
            wr(12'h02d, 8'(c << 4));
            chk("decim", (c < 2) ? 16'h0 : 16'(1 << c), {8'h0, dec});
        end
        rd(12'h02d, 8'h70);
    endtask : t_decim
    task automatic t_avg;
        logic [7:0] v[4] = '{8'h0a, 8'h08, 8'h02, 8'h0c};
        for (int i = 0; i < 4; i++) begin
            wr(12'h02e, v[i]);
            chk("avg", (i == 0) ? 16'h1 : 16'h0, {15'h0, avg});
        end
    endtask : t_avg
    task automatic t_capture;
        for (int c = 0; c < 4; c++) begin
            wr(12'h034, 8'(8'h40 | (c << 4)));
            chk("capture", 16'(8'h10 | c), {11'h0, fpd, 2'h0, cap});
        end
        wr(12'h034, 8'h00);
        chk("fastpd", 16'h0000, {15'h0, fpd});
        wr(12'h03b, 8'he4);
        wr(12'h041, 8'h1b);
        chk("osc", 16'h1be4, osc);
        rd(12'h041, 8'h1b);
    endtask : t_capture
    task automatic t_sysref(input logic [4:0] o, input logic [7:0] e);
        obs = o;
        repeat (4) @(negedge clk_in);
        sysref_in = 1'b1;
        repeat (8) @(negedge clk_in);
        sysref_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rd(12'h22f, e);
    endtask : t_sysref
    task automatic t_pins;
        logic [2:0] f[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
        wr(12'h234, 8'h43);
        chk("pins", 16'h000b, {12'h0, fast, pfn});
        wr(12'h235, 8'hff);
        chk("source", 16'h0002, {14'h0, fromreg, fast});
        wr(12'h235, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(12'h234, {5'h0, f[i]});
            chk("pinfn", {13'h0, f[i]}, {13'h0, pfn});
        end
        chk("source", 16'h0000, {14'h0, fromreg, fast});
    endtask : t_pins
    task automatic t_frames;
        u_adcr_host_model.burst({16'h002d, 8'h30, 16'h002e, 8'h0a}, 48, 1'b0);
        chk("pair", 16'h0108, {7'h0, avg, dec});
        u_adcr_host_model.burst({14'h0, 16'h002d, 8'h70, 10'h3ff}, 34, 1'b0);
        chk("partial", 16'h0080, {8'h0, dec});
        u_adcr_host_model.burst({24'h0, 16'h802d, 8'h20}, 24, 1'b1);
        chk("rdflag", 16'h0080, {8'h0, dec});
        rd(12'h123, 8'h00);
    endtask : t_frames
    task automatic t_resetbit;
        wr(12'h000, 8'h01);
        chk("default", 16'h0000, {8'h0, dec});
        rd(12'h000, 8'h01);
        wr(12'h000, 8'h00);
        wr(12'h005, 8'h02);
        rd(12'h02d, 8'h00);
    endtask : t_resetbit
    task automatic test_done;
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        rst_n_in = 1'b0;
        sysref_in = 1'b0;
        obs = 5'h00;
        fails = 0;
        samples_checked = 0;
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_reset();
        t_pages();
        t_mode();
        t_decim();
        t_avg();
        t_capture();
        t_sysref(5'h0a, 8'hab);
        t_sysref(5'h10, 8'hc3);
        t_sysref(5'h00, 8'h81);
        t_pins();
        t_frames();
        t_resetbit();
        test_done();
    end
endmodule : adcr_regs_bench
